// ==== did_pkg.sv ====
/*
  Package for the digital input debounce block: parameter addresses, field widths,
  reset values, setting codes and tick timing.
  Assumes a 125 MHz system clock.
*/
package did_pkg;

  localparam int unsigned NUM_INPUTS = 5;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CODE_W = 3;

  // Parameter addresses, one per input, two apart
  localparam logic [15:0] INPUT0_FILTER_TIME_ADDR = 16'h0840;
  localparam logic [15:0] INPUT1_FILTER_TIME_ADDR = 16'h0842;
  localparam logic [15:0] INPUT2_FILTER_TIME_ADDR = 16'h0844;
  localparam logic [15:0] INPUT3_FILTER_TIME_ADDR = 16'h0846;
  localparam logic [15:0] INPUT4_FILTER_TIME_ADDR = 16'h0848;
  localparam logic [15:0] ADDR_STEP = 16'h0002;

  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_MAX = 3'h6;
  localparam logic [2:0] FILTER_TIME_RESET = 3'h6;

  // Tick timing
  localparam int unsigned CLOCK_HZ = 125000000;
  localparam int unsigned TICK_NS = 250000;
  localparam int unsigned CLOCK_PERIOD_NS = 8;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned TICK_W = 15;
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

  typedef struct packed {
    logic write;
    logic read;
    logic [15:0] addr;
    logic [15:0] wdata;
  } did_req_type;

  typedef struct packed {
    logic ack;
    logic error;
    logic [15:0] rdata;
  } did_rsp_type;

endpackage : did_pkg

// ==== did_filter.sv ====
/*
  One debounce channel: three-stage pin synchroniser and a tick-counted hold filter.
  Assumes a shared 0.25 ms tick pulse and a legal setting code.
*/
`timescale 1ns/1ps
`default_nettype none
module did_filter
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic tick_in,
  input wire logic [2:0] code_in,
  input wire logic raw_in,
  output logic clean_out
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic [2:0] count_q;
  logic [2:0] count_d;
  logic clean_q;
  logic clean_d;
  logic stable;
  logic differs;

  assign stable = (sync2_q == sync3_q);
  assign differs = stable && (sync3_q != clean_q);

  always_comb
  begin
    count_d = count_q;
    clean_d = clean_q;
    if (code_in == did_pkg::CODE_NONE)
    begin
      if (stable)
      begin
        clean_d = sync3_q;
      end
      count_d = 3'h0;
    end
    else if (!differs)
    begin
      count_d = 3'h0;
    end
    else if (tick_in)
    begin
      if (count_q + 3'h1 >= code_in)
      begin
        clean_d = sync3_q;
        count_d = 3'h0;
      end
      else
      begin
        count_d = count_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      count_q <= 3'h0;
      clean_q <= 1'b0;
    end
    else if (enable_in)
    begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      count_q <= count_d;
      clean_q <= clean_d;
    end
  end

  assign clean_out = clean_q;

  nofilt_follow_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && code_in == 3'h0) |=>
    (clean_q == ($past(stable) ? $past(sync3_q) : $past(clean_q))))
    else $error("unfiltered input did not follow");

  hold_short_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && code_in != 3'h0 && !differs) |=> (clean_q == $past(clean_q)))
    else $error("filtered output changed without a steady new level");

endmodule : did_filter
`default_nettype wire

// ==== did_top.sv ====
/*
  Five-channel digital input debounce with its parameter registers.
  Assumes the fieldbus parameter layer presents one request per cycle as a packed
  struct and reads the answer one cycle later; power stage state comes from drive logic.
*/
`timescale 1ns/1ps
`default_nettype none
module did_top
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic power_stage_on_in,
  input wire did_pkg::did_req_type req_in,
  output did_pkg::did_rsp_type rsp_out,
  input wire logic [4:0] field_input_in,
  output logic [4:0] field_clean_out
);

  // ==========================================================
  // Tick generator, 0.25 ms
  // ==========================================================
  logic [14:0] tick_cnt_q;
  logic tick_q;
  logic tick_wrap;

  assign tick_wrap = (tick_cnt_q == did_pkg::TICK_LAST);

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      tick_cnt_q <= 15'h0000;
      tick_q <= 1'b0;
    end
    else if (enable_in)
    begin
      tick_cnt_q <= tick_wrap ? 15'h0000 : tick_cnt_q + 15'h0001;
      tick_q <= tick_wrap;
    end
  end

  // ==========================================================
  // Parameter registers
  // ==========================================================
  logic [2:0] code_q [5];
  logic [15:0] offset;
  logic [2:0] index;
  logic hit;
  logic legal_value;
  logic write_ok;
  did_pkg::did_rsp_type rsp_q;
  did_pkg::did_rsp_type rsp_d;

  assign offset = req_in.addr - did_pkg::INPUT0_FILTER_TIME_ADDR;
  assign index = offset[3:1];
  assign hit = (req_in.addr >= did_pkg::INPUT0_FILTER_TIME_ADDR) &&
               (req_in.addr <= did_pkg::INPUT4_FILTER_TIME_ADDR) && !offset[0];
  assign legal_value = (req_in.wdata <= 16'(did_pkg::CODE_MAX));
  assign write_ok = req_in.write && hit && legal_value && !power_stage_on_in;

  always_comb
  begin
    rsp_d.ack = req_in.write || req_in.read;
    rsp_d.error = (req_in.write && !write_ok) || (req_in.read && !hit);
    rsp_d.rdata = (req_in.read && hit) ? {13'h0000, code_q[index]} : 16'h0000;
  end

  generate
    for (genvar i = 0; i < 5; i++)
    begin : g_ch
      always_ff @(posedge clock_in)
      begin
        if (reset_in)
        begin
          code_q[i] <= did_pkg::FILTER_TIME_RESET;
        end
        else if (enable_in && write_ok && index == 3'(i))
        begin
          code_q[i] <= req_in.wdata[2:0];
        end
      end

      did_filter u_filter
      (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(enable_in),
        .tick_in(tick_q),
        .code_in(code_q[i]),
        .raw_in(field_input_in[i]),
        .clean_out(field_clean_out[i])
      );

      stage_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (enable_in && power_stage_on_in) |=> (code_q[i] == $past(code_q[i])))
        else $error("channel setting changed with power stage on");

      code_range_a: assert property (@(posedge clock_in) disable iff (reset_in)
        code_q[i] <= did_pkg::CODE_MAX)
        else $error("channel setting out of range");

      reset_six_a: assert property (@(posedge clock_in)
        reset_in |=> (code_q[i] == did_pkg::FILTER_TIME_RESET))
        else $error("channel setting not 6 after reset");

      write_land_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (enable_in && write_ok && index == 3'(i)) |=> (code_q[i] == $past(req_in.wdata[2:0])))
        else $error("accepted write did not reach its channel");

      other_write_a: assert property (@(posedge clock_in) disable iff (reset_in)
        (enable_in && write_ok && index != 3'(i)) |=> (code_q[i] == $past(code_q[i])))
        else $error("write to one channel changed another");
    end
  endgenerate

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      rsp_q <= '0;
    end
    else if (enable_in)
    begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_out = rsp_q;

  // ==========================================================
  // Checks
  // ==========================================================
  stage_lock_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && power_stage_on_in) |=> (code_q[0] == $past(code_q[0])))
    else $error("setting changed with power stage on");

  range_keep_a: assert property (@(posedge clock_in) disable iff (reset_in)
    code_q[1] <= 3'h6)
    else $error("setting out of range");

  write_effect_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && write_ok && index == 3'h2) |=> (code_q[2] == $past(req_in.wdata[2:0])))
    else $error("accepted write did not take effect");

  reset_code_a: assert property (@(posedge clock_in)
    reset_in |=> (code_q[3] == 3'h6))
    else $error("setting not 6 after reset");

  tick_period_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && tick_wrap) |=> (tick_cnt_q == 15'h0000))
    else $error("tick counter did not wrap");

  read_back_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && req_in.read && hit && !req_in.write) |=>
    (rsp_q.rdata[2:0] == code_q[$past(index)]))
    else $error("read returned wrong setting");

  write_refuse_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && req_in.write && power_stage_on_in) |=> (rsp_q.ack && rsp_q.error))
    else $error("write taken while power stage on");

  write_accept_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && write_ok) |=> (rsp_q.ack && !rsp_q.error))
    else $error("legal write answered with error");

  range_refuse_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && req_in.write && req_in.wdata > 16'h0006) |=> rsp_q.error)
    else $error("setting above 6 not refused");

  read_upper_a: assert property (@(posedge clock_in) disable iff (reset_in)
    rsp_q.rdata[15:3] == 13'h0000)
    else $error("read data above the code field");

  ack_answer_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && (req_in.write || req_in.read)) |=> rsp_q.ack)
    else $error("request not acknowledged");

  idle_quiet_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && !req_in.write && !req_in.read) |=> (rsp_q == '0))
    else $error("answer without a request");

  unmapped_read_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && req_in.read && !hit) |=> (rsp_q.error && rsp_q.rdata == 16'h0000))
    else $error("unmapped read not refused");

  odd_write_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && req_in.write && req_in.addr[0]) |=> rsp_q.error)
    else $error("write to odd address taken");

  read_error_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && req_in.read && !req_in.write && hit) |=> !rsp_q.error)
    else $error("mapped read answered with error");

  tick_spacing_a: assert property (@(posedge clock_in) disable iff (reset_in)
    tick_q |-> (tick_cnt_q == 15'h0000))
    else $error("tick pulse away from counter wrap");

  tick_single_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && tick_q) |=> !tick_q)
    else $error("tick pulse longer than one cycle");

  tick_count_a: assert property (@(posedge clock_in) disable iff (reset_in)
    (enable_in && !tick_wrap) |=> (tick_cnt_q == $past(tick_cnt_q) + 15'h0001))
    else $error("tick counter skipped a cycle");

  freeze_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
    !enable_in |=> (rsp_q == $past(rsp_q) && tick_cnt_q == $past(tick_cnt_q)))
    else $error("state moved while clock enable low");

endmodule : did_top
`default_nettype wire

// ==== did_field_model.sv ====
/*
  Field wiring model: drives the five raw inputs, with contact bounce on each change.
  Assumes the bench sets target levels just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module did_field_model
(
  input wire logic clock_in,
  input wire logic [4:0] level_in,
  output logic [4:0] field_out
);
  // ==========
  // Bounce
  logic [4:0] last_q = 5'h00;
  logic [4:0] moved_q = 5'h00;
  logic [2:0] bounce_q = 3'h0;
  always @(posedge clock_in)
  begin
    last_q <= level_in;
    if (level_in != last_q)
    begin
      moved_q <= level_in ^ last_q;
      bounce_q <= 3'h5;
    end
    else if (bounce_q != 3'h0)
      bounce_q <= bounce_q - 3'h1;
  end
  // Changed lines chatter for a few cycles before settling
  assign field_out = bounce_q[0] ? last_q ^ moved_q : last_q;
endmodule : did_field_model
`default_nettype wire

// ==== tb.sv ====
/*
  Self-checking bench for the debounce block.
  Assumes did_pkg, did_top and the field model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic power_stage_on_in = 1'b0;
  logic enable_in = 1'b1;
  did_pkg::did_req_type req_in = '0;
  did_pkg::did_rsp_type rsp_out;
  logic [4:0] level_q = 5'h00;
  logic [4:0] field_input_in;
  logic [4:0] field_clean_out;
  int err_total = 0;
  int checks_done = 0;
  always #4 clock_in = ~clock_in;
  did_field_model field (.clock_in(clock_in), .level_in(level_q), .field_out(field_input_in));
  did_top dut (.clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in),
    .power_stage_on_in(power_stage_on_in), .req_in(req_in), .rsp_out(rsp_out),
    .field_input_in(field_input_in), .field_clean_out(field_clean_out));
  // ==========
  // Shared tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask : check
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata,
    input logic err, input logic [15:0] rdata);
    @(posedge clock_in);
    #1;
    req_in = '{write: wr, read: !wr, addr: addr, wdata: wdata};
    @(posedge clock_in);
    #1;
    req_in = '0;
    check("ack", 16'h0001, {15'h0000, rsp_out.ack});
    check("error", {15'h0000, err}, {15'h0000, rsp_out.error});
    if (!wr)
      check("rdata", rdata, rsp_out.rdata);
  endtask : access
  task automatic wait_clean(input int n, input logic exp, input int bound);
    int i;
    i = 0;
    while (field_clean_out[n] !== exp && i < bound)
    begin
      @(posedge clock_in);
      #1;
      i++;
    end
    check("clean", {15'h0000, exp}, {15'h0000, field_clean_out[n]});
    if (field_clean_out[n] !== exp)
      end_of_test();
  endtask : wait_clean
  // ==========
  // Scenarios
  task automatic test_reset();
    for (int i = 0; i < 5; i++)
      access(1'b0, 16'h0840 + 16'(2 * i), 16'h0000, 1'b0, 16'h0006);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_refuse();
    power_stage_on_in = 1'b1;
    access(1'b1, 16'h0840, 16'h0000, 1'b1, 16'h0000);
    power_stage_on_in = 1'b0;
    access(1'b0, 16'h0840, 16'h0000, 1'b0, 16'h0006);
    access(1'b1, 16'h0844, 16'h0007, 1'b1, 16'h0000);
    access(1'b0, 16'h0844, 16'h0000, 1'b0, 16'h0006);
    access(1'b0, 16'h0841, 16'h0000, 1'b1, 16'h0000);
    access(1'b1, 16'h084A, 16'h0001, 1'b1, 16'h0000);
    $display("test_refuse done");
  endtask : test_refuse
  task automatic test_bypass();
    access(1'b1, 16'h0840, 16'h0000, 1'b0, 16'h0000);
    access(1'b0, 16'h0840, 16'h0000, 1'b0, 16'h0000);
    level_q[0] = 1'b1;
    repeat (12) @(posedge clock_in);
    #1;
    check("bypass", 16'h0001, {15'h0000, field_clean_out[0]});
    $display("test_bypass done");
  endtask : test_bypass
  task automatic test_timed();
    access(1'b1, 16'h0842, 16'h0002, 1'b0, 16'h0000);
    access(1'b1, 16'h0848, 16'h0001, 1'b0, 16'h0000);
    level_q[4:1] = 4'hF;
    repeat (31000) @(posedge clock_in);
    #1;
    check("early", 16'h0000, {15'h0000, field_clean_out[1]});
    wait_clean(1, 1'b1, 31600);
    check("short", 16'h0001, {15'h0000, field_clean_out[4]});
    check("long", 16'h0000, {14'h0000, field_clean_out[3:2]});
    $display("test_timed done");
  endtask : test_timed
  task automatic test_freeze();
    @(posedge clock_in);
    #1;
    enable_in = 1'b0;
    req_in = '{write: 1'b1, read: 1'b0, addr: 16'h0846, wdata: 16'h0001};
    repeat (2) @(posedge clock_in);
    #1;
    check("frozen ack", 16'h0000, {15'h0000, rsp_out.ack});
    req_in = '0;
    enable_in = 1'b1;
    access(1'b0, 16'h0846, 16'h0000, 1'b0, 16'h0006);
    $display("test_freeze done");
  endtask : test_freeze
  task automatic test_rereset();
    @(posedge clock_in);
    #1;
    reset_in = 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    check("clean after reset", 16'h0000, {11'h000, field_clean_out});
    access(1'b0, 16'h0842, 16'h0000, 1'b0, 16'h0006);
    access(1'b0, 16'h0848, 16'h0000, 1'b0, 16'h0006);
    $display("test_rereset done");
  endtask : test_rereset
  initial
  begin
    repeat (10) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    test_reset();
    test_refuse();
    test_freeze();
    test_bypass();
    test_timed();
    test_rereset();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
